// file: pkg/hb_regs_pkg.sv
// Constants and carriers for the half-bridge switch enable register bank
// Function
// (R1) Reset loads every control register with all eight bits zero.
// (R2) A frame is sixteen bits: address byte first, then data byte.
// (R3) Control bits change only through a serial write, never by the device.
// (R4) Address bit 7 low selects a read; the register is not changed. The code clears a status register's flags when it is read.
// (R5) Address bit 7 high selects a write of the data byte.
// (R6) First enable register: bit 7 output 4 high side to bit 0 output 1 low.
// (R7) Enable bit zero holds the switch off at high impedance; one turns it on.
// (R8) Second enable register: bit 7 output 8 high to bit 0 output 5 low.
// (R9) Both sides of one half-bridge enabled switches both sides off.
// (R10) Status flags pair high and low sides, highest output in bit 7.
package hb_regs_pkg;
    localparam int            FRAME_BITS    = 16;
    localparam logic [3:0]    FRAME_LAST    = 4'hf;
    localparam logic [3:0]    FRAME_ADDR_LAST = 4'h7;
    localparam int            ADDR_RW_BIT   = 7;
    // Address codes: bits 6..2 of the address byte, msb of code sent first
    localparam logic [4:0]    ADDR_ACT1     = 5'h00;
    localparam logic [4:0]    ADDR_ACT2     = 5'h01;
    localparam logic [4:0]    ADDR_OC_9_12  = 5'h0f;
    localparam logic [4:0]    ADDR_OL_1_4   = 5'h10;
    localparam logic [4:0]    ADDR_OL_5_8   = 5'h11;
    localparam logic [4:0]    ADDR_OL_9_12  = 5'h12;
    localparam logic [7:0]    CTRL_RESET    = 8'h00;
    localparam logic [7:0]    STATUS_RESET  = 8'h00;
    localparam int            HB_COUNT      = 8;

    typedef struct packed {
        logic [7:0] oc_9_12;
        logic [7:0] ol_1_4;
        logic [7:0] ol_5_8;
        logic [7:0] ol_9_12;
    } status_flags_s;

    typedef struct packed {
        logic [HB_COUNT-1:0] high_on;
        logic [HB_COUNT-1:0] low_on;
    } switch_drive_s;
endpackage : hb_regs_pkg

// file: hdl/hb_switch_enable_regs.sv
// Serial register bank with switch enables and status flags
`timescale 1ns/10ps
`default_nettype none
module hb_switch_enable_regs
    import hb_regs_pkg::*;
(
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset,
    input  wire logic          i_sclk,
    input  wire logic          i_csn,
    input  wire logic          i_sdi,
    output logic               o_sdo,
    output logic               o_sdo_oe_n,
    input  wire status_flags_s i_status_set,
    output switch_drive_s      o_drive
);
    typedef enum logic [1:0] {
        IDLE  = 2'b00,
        SHIFT = 2'b01,
        DONE  = 2'b10
    } frame_e;

    // Two-flop synchronisers for the serial pins
    logic [2:0] sclk_sync;
    logic [1:0] csn_sync;
    logic [1:0] sdi_sync;
    logic       sclk_prev;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sclk_sync <= 3'h0;
            csn_sync  <= 2'h3;
            sdi_sync  <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], i_sclk};
            csn_sync  <= {csn_sync[0], i_csn};
            sdi_sync  <= {sdi_sync[0], i_sdi};
        end
    end
    assign sclk_prev = sclk_sync[2];
    wire sclk_s   = sclk_sync[1];
    wire csn_s    = csn_sync[1];
    wire sdi_s    = sdi_sync[1];
    wire sclk_rise = sclk_s & ~sclk_prev;
    wire sclk_fall = ~sclk_s & sclk_prev;

    frame_e      state;
    frame_e      next_state;
    logic [3:0]  bit_cnt;
    logic [3:0]  next_bit_cnt;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic [7:0]  act1;
    logic [7:0]  next_act1;
    logic [7:0]  act2;
    logic [7:0]  next_act2;
    status_flags_s flags;
    status_flags_s next_flags;
    logic [7:0]  tx;
    logic [7:0]  next_tx;
    logic        sdo;
    logic        next_sdo;

    // Frame fields once all sixteen bits are in
    wire [7:0] addr_byte = shreg[15:8];
    wire [7:0] data_byte = shreg[7:0];
    wire [4:0] addr_code = addr_byte[6:2];
    wire       is_write  = addr_byte[ADDR_RW_BIT];
    wire       last_bit  = sclk_rise && (bit_cnt == FRAME_LAST);
    wire       frame_end = (state == DONE) && csn_s;

    function automatic logic [7:0] read_reg(input logic [4:0] code,
                                            input logic [7:0] a1,
                                            input logic [7:0] a2,
                                            input status_flags_s f);
        case (code)
            ADDR_ACT1:    read_reg = a1;
            ADDR_ACT2:    read_reg = a2;
            ADDR_OC_9_12: read_reg = f.oc_9_12;
            ADDR_OL_1_4:  read_reg = f.ol_1_4;
            ADDR_OL_5_8:  read_reg = f.ol_5_8;
            ADDR_OL_9_12: read_reg = f.ol_9_12;
            default:      read_reg = 8'h00;
        endcase
    endfunction : read_reg

    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_act1    = act1;
        next_act2    = act2;
        next_tx      = tx;
        next_sdo     = sdo;
        // Hardware set wins over a read clear in the same cycle
        next_flags   = flags | i_status_set;
        case (state)
            IDLE: begin
                if (!csn_s) begin
                    next_state   = SHIFT;
                    next_bit_cnt = 4'h0;
                end
            end
            SHIFT: begin
                if (csn_s) begin
                    // Short frame is dropped, nothing stored
                    next_state = IDLE;
                end else if (sclk_rise) begin
                    next_shreg   = {shreg[14:0], sdi_s}; // (R2)
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (last_bit) begin
                        next_state = DONE;
                    end
                end
                if (sclk_fall) begin
                    next_sdo = tx[7];
                    next_tx  = {tx[6:0], 1'b0};
                end
                if (bit_cnt == FRAME_ADDR_LAST && sclk_rise) begin
                    // Load on the last address rise: first data bit
                    // must stand before the master's ninth rise
                    next_tx = read_reg(shreg[5:1], act1, act2, flags); // (R4)
                end
            end
            DONE: begin
                // Extra clocks make the frame invalid; commit at csn rise
                if (sclk_rise) begin
                    next_state = IDLE;
                end else if (csn_s) begin
                    next_state = IDLE;
                    if (is_write) begin // (R5)
                        case (addr_code)
                            ADDR_ACT1: next_act1 = data_byte; // (R3) (R6)
                            ADDR_ACT2: next_act2 = data_byte; // (R3) (R8)
                            default:   ;
                        endcase
                    end else begin // (R4)
                        case (addr_code)
                            ADDR_OC_9_12: next_flags.oc_9_12 = i_status_set.oc_9_12;
                            ADDR_OL_1_4:  next_flags.ol_1_4  = i_status_set.ol_1_4;
                            ADDR_OL_5_8:  next_flags.ol_5_8  = i_status_set.ol_5_8;
                            ADDR_OL_9_12: next_flags.ol_9_12 = i_status_set.ol_9_12;
                            default:      ;
                        endcase
                    end
                end
            end
            default: next_state = IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state   <= IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 16'h0000;
            act1    <= CTRL_RESET; // (R1)
            act2    <= CTRL_RESET; // (R1)
            flags   <= {4{STATUS_RESET}};
            tx      <= 8'h00;
            sdo     <= 1'b0;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            act1    <= next_act1;
            act2    <= next_act2;
            flags   <= next_flags; // (R10)
            tx      <= next_tx;
            sdo     <= next_sdo;
        end
    end

    assign o_sdo      = sdo;
    assign o_sdo_oe_n = csn_s;

    // Drive stage; registered so switches never see a glitch
    switch_drive_s next_drive;
    switch_drive_s drive;
    wire [15:0] en_all = {act2, act1};
    wire [HB_COUNT-1:0] next_high;
    wire [HB_COUNT-1:0] next_low;
    generate
        for (genvar g = 0; g < HB_COUNT; g++) begin : g_hb
            wire hs = en_all[2*g+1];
            wire ls = en_all[2*g];
            // Both set: whole half-bridge off
            assign next_high[g] = hs & ~ls; // (R7) (R9)
            assign next_low[g]  = ls & ~hs; // (R7) (R9)
        end
    endgenerate
    assign next_drive = {next_high, next_low};
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            drive <= '0;
        end else begin
            drive <= next_drive;
        end
    end
    assign o_drive = drive;

    // Reset and drive stage checks
    chk_reset_clear: assert property (@(posedge i_ref_clk) // (R1)
        i_reset |=> (act1 == CTRL_RESET && act2 == CTRL_RESET))
        else $error("control registers not zero after reset");

    chk_no_cross: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R9)
        (drive.high_on & drive.low_on) == '0)
        else $error("both sides of a half-bridge on");

    chk_both_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R9)
        (act1[1] && act1[0]) |=> (!drive.high_on[0] && !drive.low_on[0]))
        else $error("half-bridge 1 not off with both enables");

    chk_hs_on: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R6)
        (act1[7] && !act1[6]) |=> drive.high_on[3])
        else $error("output 4 high side not on");

    chk_ls_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R7)
        !act2[0] |=> !drive.low_on[4])
        else $error("output 5 low side on while disabled");

    chk_ls_on: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R8)
        (act2[0] && !act2[1]) |=> drive.low_on[4])
        else $error("output 5 low side not on");

    chk_hs_off: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R7)
        !act1[1] |=> !drive.high_on[0])
        else $error("output 1 high side on while disabled");

    // Frame and register access checks
    chk_ctrl_stable: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R3)
        !(state == DONE && csn_s && is_write) |=> $stable(act1) && $stable(act2))
        else $error("control register changed without a write");

    chk_write_store: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R5)
        (frame_end && is_write && addr_code == ADDR_ACT2 && !sclk_rise)
        |=> act2 == $past(data_byte))
        else $error("write data not stored");

    chk_act1_store: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R5)
        (frame_end && is_write && addr_code == ADDR_ACT1 && !sclk_rise)
        |=> act1 == $past(data_byte))
        else $error("first enable write not stored");

    chk_read_keeps: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R4)
        (frame_end && !is_write) |=> $stable(act1) && $stable(act2))
        else $error("read frame altered a control register");

    chk_read_load: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R4)
        (state == SHIFT && sclk_rise && bit_cnt == FRAME_ADDR_LAST
         && shreg[5:1] == ADDR_ACT1)
        |=> tx == $past(act1))
        else $error("read data not loaded after address byte");

    chk_frame_len: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R2)
        (state == SHIFT && last_bit && !csn_s) |=> state == DONE)
        else $error("frame not complete after sixteen bits");

    chk_short_drop: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R2)
        (state == SHIFT && csn_s) |=> state == IDLE)
        else $error("short frame not dropped");

    // Extra clock after sixteen bits voids the frame
    chk_long_drop: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R2)
        (state == DONE && sclk_rise)
        |=> state == IDLE && $stable(act1) && $stable(act2))
        else $error("long frame not dropped");

    // Status flag checks
    chk_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R10)
        i_status_set.oc_9_12[7] |=> flags.oc_9_12[7])
        else $error("overcurrent flag lost");

    chk_ol_sticky: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R10)
        i_status_set.ol_9_12[0] |=> flags.ol_9_12[0])
        else $error("open load flag lost");

    chk_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset) // (R10)
        (frame_end && !is_write && !sclk_rise && addr_code == ADDR_OL_1_4
         && i_status_set.ol_1_4 == 8'h00)
        |=> flags.ol_1_4 == 8'h00)
        else $error("open load flags not cleared by read");

    cov_write1: cover property (@(posedge i_ref_clk)
        frame_end && is_write && addr_code == ADDR_ACT1);

    cov_read_ol: cover property (@(posedge i_ref_clk)
        frame_end && !is_write && addr_code == ADDR_OL_1_4);

    cov_cross: cover property (@(posedge i_ref_clk) act2[7] && act2[6]);

    cov_short_drop: cover property (@(posedge i_ref_clk)
        state == SHIFT && csn_s);

    cov_long_drop: cover property (@(posedge i_ref_clk)
        state == DONE && sclk_rise);
endmodule : hb_switch_enable_regs
`default_nettype wire

// file: tb/hb_spi_master.sv
// Serial master model that frames commands for the register bank
`timescale 1ns/10ps
`default_nettype none
module hb_spi_master (
    input  wire logic i_ref_clk,
    input  wire logic i_sdo_line,
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_sdi
);
    // Phase above the 3 clock minimum, to absorb the sync lag
    localparam int PHASE = 6;
    initial begin
        o_sclk = 1'b0;
        o_csn  = 1'b1;
        o_sdi  = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : idle
    task automatic frame(input logic [7:0] addr, input logic [7:0] data,
                         input int nbits, output logic [7:0] rdata);
        logic [15:0] word;
        word  = {addr, data};
        rdata = 8'h00;
        o_csn = 1'b0;
        idle(PHASE);
        for (int i = 0; i < nbits; i++) begin
            o_sdi = word[15 - (i % 16)];
            idle(PHASE);
            if (i >= 8 && i < 16) begin
                rdata = {rdata[6:0], i_sdo_line};
            end
            o_sclk = 1'b1;
            idle(PHASE);
            o_sclk = 1'b0;
        end
        idle(PHASE);
        o_csn = 1'b1;
        // Released line must not keep showing its last value
        o_sdi = ~o_sdi;
        idle(10);
    endtask : frame
endmodule : hb_spi_master
`default_nettype wire

// file: tb/hb_switch_enable_regs_tb.sv
// Self-checking bench for the switch enable register bank
`timescale 1ns/10ps
`default_nettype none
module hb_switch_enable_regs_tb;
    import hb_regs_pkg::*;
    logic          ref_clk;
    logic          reset;
    logic          sclk;
    logic          csn;
    logic          sdi;
    logic          sdo;
    logic          sdo_oe_n;
    wire           sdo_line;
    status_flags_s status_set;
    switch_drive_s drive;
    int            failures;
    int            check_count;
    logic [7:0]    rd;
    logic [7:0]    a1;
    logic [7:0]    a2;
    logic [15:0]   en;
    logic [4:0]    st_code [4];
    assign sdo_line = sdo_oe_n ? 1'bz : sdo;
    hb_switch_enable_regs i_hb_switch_enable_regs (.i_ref_clk(ref_clk),
        .i_reset(reset), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_status_set(status_set),
        .o_drive(drive));
    hb_spi_master i_hb_spi_master (.i_ref_clk(ref_clk),
        .i_sdo_line(sdo_line), .o_sclk(sclk), .o_csn(csn), .o_sdi(sdi));
    always #5 ref_clk = ~ref_clk;
    function automatic switch_drive_s exp_drive(input logic [7:0] x1,
                                                input logic [7:0] x2);
        logic [15:0]   e;
        switch_drive_s d;
        e = {x2, x1};
        for (int k = 0; k < 8; k++) begin
            d.high_on[k] = e[2*k+1] & ~e[2*k];
            d.low_on[k]  = e[2*k] & ~e[2*k+1];
        end
        return d;
    endfunction : exp_drive
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] code, input logic [7:0] d,
                      input int n);
        i_hb_spi_master.frame({1'b1, code, 2'b00}, d, n, rd);
    endtask : wr
    task automatic rdr(input logic [4:0] code, output logic [7:0] q);
        i_hb_spi_master.frame({1'b0, code, 2'b00}, 8'hff, 16, q);
    endtask : rdr
    task automatic finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #1000000;
        failures++;
        finish_test();
    end
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        status_set = '0;
        failures = 0;
        check_count = 0;
        st_code = '{ADDR_OC_9_12, ADDR_OL_1_4, ADDR_OL_5_8, ADDR_OL_9_12};
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
        check("drive", drive, 16'h0000);
        check("sdo_oe_n", sdo_oe_n, 1'b1);
        rdr(ADDR_ACT1, rd);
        check("act1", rd, CTRL_RESET);
        rdr(ADDR_ACT2, rd);
        check("act2", rd, CTRL_RESET);
        for (int b = 0; b < 16; b++) begin
            en = 16'h0001 << b;
            a1 = en[7:0];
            a2 = en[15:8];
            wr(ADDR_ACT1, a1, 16);
            wr(ADDR_ACT2, a2, 16);
            check("drive", drive, exp_drive(a1, a2));
            rdr(ADDR_ACT1, rd);
            check("act1", rd, a1);
            rdr(ADDR_ACT2, rd);
            check("act2", rd, a2);
        end
        // Both sides of outputs 1 and 7 requested together
        a1 = 8'h83;
        a2 = 8'h36;
        wr(ADDR_ACT1, a1, 16);
        wr(ADDR_ACT2, a2, 16);
        repeat (200) @(negedge ref_clk);
        check("drive", drive, exp_drive(a1, a2));
        rdr(ADDR_ACT1, rd);
        check("act1", rd, a1);
        rdr(ADDR_ACT1, rd);
        check("act1", rd, a1);
        wr(ADDR_ACT2, 8'h55, 15);
        wr(ADDR_ACT2, 8'h55, 17);
        rdr(ADDR_ACT2, rd);
        check("act2", rd, a2);
        check("drive", drive, exp_drive(a1, a2));
        for (int r = 0; r < 4; r++) begin
            status_set[31 - 8*r -: 8] = 8'h80 | (8'h01 << r);
            @(negedge ref_clk);
            status_set = '0;
            wr(st_code[r], 8'h00, 16);
            rdr(st_code[r], rd);
            check("flags", rd, 8'h80 | (8'h01 << r));
            rdr(st_code[r], rd);
            check("flags", rd, STATUS_RESET);
        end
        rdr(5'h1f, rd);
        check("unknown", rd, 8'h00);
        finish_test();
    end
endmodule : hb_switch_enable_regs_tb
`default_nettype wire
